// ==== rtl/flash_host_pkg.sv ====
package flash_host_pkg;

  // Clock and bus geometry
  localparam int CLK_PERIOD_NS = 10;  // mclk period
  localparam int ADDR_W        = 24;  // Byte address width
  localparam int DATA_W        = 16;  // Full data bus width
  localparam int BYTE_W        = 8;   // Byte lane width
  localparam int PAGE_LSB      = 4;   // Lowest address bit of the page tag
  localparam int CNT_W         = 8;   // Width of the interval counter
  localparam int SYNC_STAGES   = 2;   // Flip-flops in each pin synchroniser

  // Pin timing in ns
  localparam int T_ACC_NS  = 75;   // Initial access
  localparam int T_PAGE_NS = 25;   // In-page access
  localparam int T_WP_NS   = 60;   // Write pulse low
  localparam int T_WHGL_NS = 35;   // Write recovery before read
  localparam int T_PLPH_NS = 100;  // Reset pulse low
  localparam int T_PHRH_NS = 100;  // Reset high to busy pin settled

  // Least time in ns to whole clock cycles, never below one
  function automatic logic [CNT_W-1:0] nsToCycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction : nsToCycles

  // Cycle counts; reads add the synchroniser latency
  localparam logic [CNT_W-1:0] SYNC_CYC  = CNT_W'(SYNC_STAGES);
  localparam logic [CNT_W-1:0] ACC_CYC   = nsToCycles(T_ACC_NS) + SYNC_CYC;
  localparam logic [CNT_W-1:0] PAGE_CYC  = nsToCycles(T_PAGE_NS) + SYNC_CYC;
  localparam logic [CNT_W-1:0] WP_CYC    = nsToCycles(T_WP_NS);
  localparam logic [CNT_W-1:0] WHGL_CYC  = nsToCycles(T_WHGL_NS);
  localparam logic [CNT_W-1:0] PLPH_CYC  = nsToCycles(T_PLPH_NS);
  localparam logic [CNT_W-1:0] PHRH_CYC  = nsToCycles(T_PHRH_NS) + SYNC_CYC;
  localparam logic [CNT_W-1:0] CNT_LAST  = 8'h01;  // Final count of a wait

  // Data lane enables
  localparam logic [DATA_W-1:0] LANES_WORD = 16'hFFFF;
  localparam logic [DATA_W-1:0] LANES_BYTE = 16'h00FF;
  localparam logic [DATA_W-1:0] LANES_NONE = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO  = 8'h00;

  // Controller states
  typedef enum logic [2:0] {
    ST_RST_LOW  = 3'h0,  // Reset pin held low
    ST_RST_WAIT = 3'h1,  // Waiting for busy pin release
    ST_WAKE     = 3'h2,  // Reset-to-output delay
    ST_IDLE     = 3'h3,  // Ready for a request
    ST_READ     = 3'h4,  // Output enable low, waiting for data
    ST_WR_LOW   = 3'h5,  // Write strobe low
    ST_WR_HIGH  = 3'h6   // Write recovery
  } hostState_t;

endpackage : flash_host_pkg

// ==== rtl/flash_sync_if.sv ====
`timescale 1ns/1ps
// Raw pin levels in, synchronised levels out
interface flash_sync_if;
  logic [flash_host_pkg::DATA_W-1:0] dqRaw;   // Data pins as seen
  logic                              stsRaw;  // Ready status pin as seen
  logic [flash_host_pkg::DATA_W-1:0] dqSync;  // Data after two flops
  logic                              stsSync; // Status after two flops

  modport sync (input dqRaw, stsRaw, output dqSync, stsSync);
  modport user (output dqRaw, stsRaw, input dqSync, stsSync);
endinterface : flash_sync_if

// ==== rtl/flash_pin_sync.sv ====
`timescale 1ns/1ps
module flash_pin_sync (
  input  wire logic     mclk,
  input  wire logic     rst,
  flash_sync_if.sync    pins
);

  logic [flash_host_pkg::DATA_W-1:0] dqMeta_reg;   // First stage, data
  logic [flash_host_pkg::DATA_W-1:0] dqHold_reg;   // Second stage, data
  logic                              stsMeta_reg;  // First stage, status
  logic                              stsHold_reg;  // Second stage, status

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dqMeta_reg  <= flash_host_pkg::LANES_NONE;
      dqHold_reg  <= flash_host_pkg::LANES_NONE;
      stsMeta_reg <= 1'b0;
      stsHold_reg <= 1'b0;
    end else begin
      dqMeta_reg  <= pins.dqRaw;
      dqHold_reg  <= dqMeta_reg;
      stsMeta_reg <= pins.stsRaw;
      stsHold_reg <= stsMeta_reg;
    end
  end

  assign pins.dqSync  = dqHold_reg;
  assign pins.stsSync = stsHold_reg;

endmodule : flash_pin_sync

// ==== rtl/flash_host_ctrl.sv ====
// Overview of operation
// [R1] Wait reset delay after later of reset, ready
// [R2] Selected, output enabled, strobe high gives read data
// [R3] Never assert output enable with write strobe
// [R4] Device favours output enable on overlap
// [R5] Byte mode uses low eight lanes only
// [R6] Lockout supply level blocks alterations, not reads
// [R7] Ready pin low while algorithm runs
// [R8] Ready pin released when idle or suspended
// [R9] Select decode from three chip-select pins
// [R10] Tie selects one, two low; use zero
// [R11] Reads never change stored contents
// [R12] Read: select, output enable, no write, no reset
// [R13] Eight-word page reads are the only mode
// [R14] First page data is the starting address
// [R15] Low address bits pick word or byte
// [R16] In-page address changes use short access
// [R17] Page data readable repeatedly, any order
// [R18] Upper address change or reselect reloads page
// [R19] Issue read-array command before array page reads
// [R20] Register reads load a single word
// [R21] Page-length setting ignored for reads
// [R22] Internal sequencer runs erase and program
// [R23] Command latched on first rising strobe or select
// [R24] Deselect gives standby, data lines released
// [R25] Leaving reset restores read-array mode
// [R26] Output disable and reset float the data lines
// [R27] Write cycle: strobe low, data lines inputs
`timescale 1ns/1ps
module flash_host_ctrl #(
  parameter int RESET_TO_OUTPUT_DELAY_NS = 150  // Wake-up delay after reset
) (
  input  wire logic                                mclk,
  input  wire logic                                rst,
  // User request side
  input  wire logic                                reqValid,
  input  wire logic                                reqWrite,
  input  wire logic [flash_host_pkg::ADDR_W-1:0]   reqAddr,
  input  wire logic [flash_host_pkg::DATA_W-1:0]   reqData,
  input  wire logic                                byteMode,
  input  wire logic                                programEnable,
  output logic                                     reqReady,
  output logic                                     respValid,
  output logic [flash_host_pkg::DATA_W-1:0]        respData,
  output logic                                     deviceBusy,
  // Flash pins
  output logic [flash_host_pkg::ADDR_W-1:0]        flashAddr,
  output logic [flash_host_pkg::DATA_W-1:0]        dqOut,
  output logic [flash_host_pkg::DATA_W-1:0]        dqOe,
  input  wire logic [flash_host_pkg::DATA_W-1:0]   dqIn,
  output logic                                     chipSelectZero,
  output logic                                     chipSelectOne,
  output logic                                     chipSelectTwo,
  output logic                                     outputEnableN,
  output logic                                     writeEnableN,
  output logic                                     resetPowerdownN,
  output logic                                     wordWidthSel,
  output logic                                     programEnableSupply,
  input  wire logic                                readyStatusPin
);

  localparam int TAG_W = flash_host_pkg::ADDR_W - flash_host_pkg::PAGE_LSB;
  // Reset-to-output wait in cycles
  localparam logic [flash_host_pkg::CNT_W-1:0] PHQV_CYC =
    flash_host_pkg::nsToCycles(RESET_TO_OUTPUT_DELAY_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  flash_sync_if syncBus ();  // Raw and synchronised pin levels

  assign syncBus.dqRaw  = dqIn;
  assign syncBus.stsRaw = readyStatusPin;

  flash_pin_sync pinSync (
    .mclk (mclk),
    .rst  (rst),
    .pins (syncBus.sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  flash_host_pkg::hostState_t             state_reg, state_next;  // Phase
  logic [flash_host_pkg::CNT_W-1:0]       cnt_reg, cnt_next;      // Wait
  logic [flash_host_pkg::ADDR_W-1:0]      addr_reg, addr_next;    // Address
  logic [flash_host_pkg::DATA_W-1:0]      dqOut_reg, dqOut_next;  // Data out
  logic [flash_host_pkg::DATA_W-1:0]      dqOe_reg, dqOe_next;    // Lanes
  logic                                   cs0_reg, cs0_next;      // Select
  logic                                   oeN_reg, oeN_next;      // Out en
  logic                                   weN_reg, weN_next;      // Strobe
  logic                                   rpN_reg, rpN_next;      // Reset pin
  logic                                   word_reg, word_next;    // x16
  logic                                   program_enable_supply_reg, program_enable_supply_next;    // Supply
  logic                                   rdy_reg, rdy_next;      // Ready
  logic                                   rv_reg, rv_next;        // Resp
  logic [flash_host_pkg::DATA_W-1:0]      rd_reg, rd_next;        // Resp data
  logic                                   busy_reg, busy_next;    // Busy
  logic                                   pgOk_reg, pgOk_next;    // Page ok
  logic [TAG_W-1:0]                       tag_reg, tag_next;      // Page tag
  logic                                   pageHit;                // Short read

  // Same page, still selected, same width: short access
  assign pageHit = pgOk_reg && !cs0_reg && (word_reg == !byteMode) &&
                   (reqAddr[flash_host_pkg::ADDR_W-1:flash_host_pkg::PAGE_LSB]
                    == tag_reg);  // [R16] [R17] [R18]

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    addr_next  = addr_reg;
    dqOut_next = dqOut_reg;
    dqOe_next  = dqOe_reg;
    cs0_next   = cs0_reg;
    oeN_next   = oeN_reg;
    weN_next   = weN_reg;
    rpN_next   = rpN_reg;
    word_next  = word_reg;
    program_enable_supply_next  = programEnable;     // [R6]
    rdy_next   = rdy_reg;
    rv_next    = 1'b0;
    rd_next    = rd_reg;
    busy_next  = !syncBus.stsSync;  // [R7] [R8]
    pgOk_next  = pgOk_reg;
    tag_next   = tag_reg;
    case (state_reg)
      // Hold reset low for the pulse time, bus idle
      flash_host_pkg::ST_RST_LOW: begin
        cnt_next = cnt_reg - flash_host_pkg::CNT_LAST;
        if (cnt_reg == flash_host_pkg::CNT_LAST) begin
          rpN_next   = 1'b1;
          cnt_next   = flash_host_pkg::PHRH_CYC;
          state_next = flash_host_pkg::ST_RST_WAIT;
        end
      end
      // Let the ready pin settle, then wait for it high
      flash_host_pkg::ST_RST_WAIT: begin
        if (cnt_reg > flash_host_pkg::CNT_LAST) begin
          cnt_next = cnt_reg - flash_host_pkg::CNT_LAST;
        end else if (syncBus.stsSync) begin
          cnt_next   = PHQV_CYC;  // [R1]
          state_next = flash_host_pkg::ST_WAKE;
        end
      end
      // Delay counted from the later of the two rising edges
      flash_host_pkg::ST_WAKE: begin
        cnt_next = cnt_reg - flash_host_pkg::CNT_LAST;
        if (cnt_reg == flash_host_pkg::CNT_LAST) begin
          rdy_next   = 1'b1;  // [R1] [R25]
          state_next = flash_host_pkg::ST_IDLE;
        end
      end
      // Accept a request
      flash_host_pkg::ST_IDLE: begin
        if (reqValid) begin
          rdy_next  = 1'b0;
          addr_next = reqAddr;
          word_next = !byteMode;  // [R5]
          cs0_next  = 1'b0;       // [R9] [R10]
          if (reqWrite) begin
            // Output enable is already high here
            dqOut_next = reqData;
            dqOe_next  = byteMode ? flash_host_pkg::LANES_BYTE
                                  : flash_host_pkg::LANES_WORD;  // [R5] [R27]
            weN_next   = 1'b0;  // [R3] [R27]
            pgOk_next  = 1'b0;  // [R19]
            cnt_next   = flash_host_pkg::WP_CYC;
            state_next = flash_host_pkg::ST_WR_LOW;
          end else begin
            dqOe_next  = flash_host_pkg::LANES_NONE;
            oeN_next   = 1'b0;  // [R2] [R12]
            cnt_next   = pageHit ? flash_host_pkg::PAGE_CYC
                                 : flash_host_pkg::ACC_CYC;  // [R13] [R16]
            pgOk_next  = 1'b1;
            tag_next   =
              reqAddr[flash_host_pkg::ADDR_W-1:flash_host_pkg::PAGE_LSB];
            state_next = flash_host_pkg::ST_READ;
          end
        end
      end
      // Sample data at the end of the access time
      flash_host_pkg::ST_READ: begin
        cnt_next = cnt_reg - flash_host_pkg::CNT_LAST;
        if (cnt_reg == flash_host_pkg::CNT_LAST) begin
          rd_next    = word_reg ? syncBus.dqSync
                       : {flash_host_pkg::BYTE_ZERO,
                          syncBus.dqSync[flash_host_pkg::BYTE_W-1:0]};  // [R5]
          rv_next    = 1'b1;  // [R14] [R15]
          oeN_next   = 1'b1;  // Select stays low to keep the page [R26]
          rdy_next   = 1'b1;
          state_next = flash_host_pkg::ST_IDLE;
        end
      end
      // Strobe low for the write pulse
      flash_host_pkg::ST_WR_LOW: begin
        cnt_next = cnt_reg - flash_host_pkg::CNT_LAST;
        if (cnt_reg == flash_host_pkg::CNT_LAST) begin
          weN_next   = 1'b1;  // [R23]
          cnt_next   = flash_host_pkg::WHGL_CYC;
          state_next = flash_host_pkg::ST_WR_HIGH;
        end
      end
      // Hold one cycle after the strobe rises, then release and recover
      flash_host_pkg::ST_WR_HIGH: begin
        cnt_next  = cnt_reg - flash_host_pkg::CNT_LAST;
        cs0_next  = 1'b1;                          // [R24]
        dqOe_next = flash_host_pkg::LANES_NONE;
        if (cnt_reg == flash_host_pkg::CNT_LAST) begin
          rv_next    = 1'b1;
          rdy_next   = 1'b1;
          state_next = flash_host_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = flash_host_pkg::ST_RST_LOW;
        cnt_next   = flash_host_pkg::PLPH_CYC;
        rpN_next   = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; reset holds the device in reset/power-down
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= flash_host_pkg::ST_RST_LOW;
      cnt_reg   <= flash_host_pkg::PLPH_CYC;
      addr_reg  <= '0;
      dqOut_reg <= flash_host_pkg::LANES_NONE;
      dqOe_reg  <= flash_host_pkg::LANES_NONE;
      cs0_reg   <= 1'b1;
      oeN_reg   <= 1'b1;
      weN_reg   <= 1'b1;
      rpN_reg   <= 1'b0;
      word_reg  <= 1'b1;
      program_enable_supply_reg  <= 1'b0;
      rdy_reg   <= 1'b0;
      rv_reg    <= 1'b0;
      rd_reg    <= flash_host_pkg::LANES_NONE;
      busy_reg  <= 1'b1;
      pgOk_reg  <= 1'b0;
      tag_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
      dqOut_reg <= dqOut_next;
      dqOe_reg  <= dqOe_next;
      cs0_reg   <= cs0_next;
      oeN_reg   <= oeN_next;
      weN_reg   <= weN_next;
      rpN_reg   <= rpN_next;
      word_reg  <= word_next;
      program_enable_supply_reg  <= program_enable_supply_next;
      rdy_reg   <= rdy_next;
      rv_reg    <= rv_next;
      rd_reg    <= rd_next;
      busy_reg  <= busy_next;
      pgOk_reg  <= pgOk_next;
      tag_reg   <= tag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops; selects one and two tied low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chipSelectOne <= 1'b0;
      chipSelectTwo <= 1'b0;
    end else begin
      chipSelectOne <= 1'b0;  // [R10]
      chipSelectTwo <= 1'b0;
    end
  end

  assign reqReady            = rdy_reg;
  assign respValid           = rv_reg;
  assign respData            = rd_reg;
  assign deviceBusy          = busy_reg;
  assign flashAddr           = addr_reg;
  assign dqOut               = dqOut_reg;
  assign dqOe                = dqOe_reg;
  assign chipSelectZero      = cs0_reg;
  assign outputEnableN       = oeN_reg;
  assign writeEnableN        = weN_reg;
  assign resetPowerdownN     = rpN_reg;
  assign wordWidthSel        = word_reg;
  assign programEnableSupply = program_enable_supply_reg;

endmodule : flash_host_ctrl

// ==== verification/flash_host_assertions.sv ====
`timescale 1ns/1ps
// Port-level timing relations of the flash controller
module flash_host_assertions #(
  parameter int RESET_TO_OUTPUT_DELAY_NS = 150  // Same as design
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        reqValid,
  input wire logic        reqWrite,
  input wire logic        byteMode,
  input wire logic        reqReady,
  input wire logic        respValid,
  input wire logic        deviceBusy,
  input wire logic [15:0] dqOe,
  input wire logic        chipSelectZero,
  input wire logic        chipSelectOne,
  input wire logic        chipSelectTwo,
  input wire logic        outputEnableN,
  input wire logic        writeEnableN,
  input wire logic        resetPowerdownN,
  input wire logic        wordWidthSel,
  input wire logic        readyStatusPin
);
  ////////////////////////////////////////
  logic take;  // Request accepted here
  assign take = reqValid && reqReady;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Read wait: page hit up to full miss
  sequence rdWait;
    (!respValid)[*4] ##[1:7] respValid;
  endsequence
  // Strobe low for the whole pulse, then up
  sequence wrPulse;
    (!writeEnableN && outputEnableN)[*6] ##1 writeEnableN;
  endsequence
  AST_OE_WE_EXCL: assert property (outputEnableN || writeEnableN)
    else $error("output enable and write strobe both low");
  AST_SEL_TIED: assert property (!chipSelectOne && !chipSelectTwo)
    else $error("select one or two not held low");
  AST_WAKE_HOLD: assert property ($rose(resetPowerdownN) |-> (!reqReady)[*8])
    else $error("ready too soon after reset release");
  AST_READ_START: assert property (take && !reqWrite |=>
    !outputEnableN && !chipSelectZero && writeEnableN && resetPowerdownN)
    else $error("read cycle pins wrong");
  AST_READ_DONE: assert property (take && !reqWrite |=> rdWait)
    else $error("read answer out of window");
  AST_WRITE_PULSE: assert property (take && reqWrite |=> wrPulse)
    else $error("write pulse wrong");
  AST_NO_DRIVE_READ: assert property (!outputEnableN |->
    dqOe == flash_host_pkg::LANES_NONE)
    else $error("host drives while device outputs");
  AST_WRITE_DRIVE: assert property (!writeEnableN |->
    dqOe != flash_host_pkg::LANES_NONE && !chipSelectZero)
    else $error("write strobe without data or select");
  AST_WIDTH_SEL: assert property (take |=> wordWidthSel == !$past(byteMode))
    else $error("width pin wrong");
  AST_BUSY_LOW: assert property ((!readyStatusPin)[*4] |-> deviceBusy)
    else $error("busy not shown");
  AST_BUSY_HIGH: assert property (readyStatusPin[*4] |-> !deviceBusy)
    else $error("busy shown while released");
  AST_RESET_FLOAT: assert property (!resetPowerdownN |->
    dqOe == flash_host_pkg::LANES_NONE && outputEnableN)
    else $error("lines driven in reset");
endmodule : flash_host_assertions

bind flash_host_ctrl flash_host_assertions #(
  .RESET_TO_OUTPUT_DELAY_NS(RESET_TO_OUTPUT_DELAY_NS)
) chk (.mclk, .rst, .reqValid, .reqWrite, .byteMode, .reqReady,
  .respValid, .deviceBusy, .dqOe, .chipSelectZero, .chipSelectOne,
  .chipSelectTwo, .outputEnableN, .writeEnableN, .resetPowerdownN,
  .wordWidthSel, .readyStatusPin);

// ==== verification/flash_device_model.sv ====
`timescale 1ns/1ps
// Behavioural flash part on the far side of the pins
module flash_device_model #(
  parameter int BUSY_CYC = 30  // Program time in mclk cycles
) (
  input wire logic        mclk,
  input wire logic [23:0] flashAddr,
  input wire logic [15:0] dqOut,
  input wire logic [15:0] dqOe,
  output logic     [15:0] dqIn,
  input wire logic        chipSelectZero,
  input wire logic        chipSelectOne,
  input wire logic        chipSelectTwo,
  input wire logic        outputEnableN,
  input wire logic        writeEnableN,
  input wire logic        resetPowerdownN,
  input wire logic        wordWidthSel,
  input wire logic        programEnableSupply,
  output logic            readyStatusPin
);
  ////////////////////////////////////////
  logic [15:0] mem [int];                  // Programmed words
  logic [15:0] lastQ = 16'h0000;           // Last line levels
  logic [15:0] devQ  = 16'h0000;           // Output value
  logic [15:0] devOn = 16'h0000;           // Output lanes on
  logic        tick  = 1'b0;               // Re-evaluation tick
  logic        sel;                        // Device selected
  logic        statusMode = 1'b0;          // Reads give status
  logic        armed = 1'b0;               // Next write programs
  realtime     tSense = 0, tAddr = 0, tOe = 0;
  int          busyCnt = 0;                // Program in progress
  function automatic logic [15:0] arrayWord(input int w);
    return mem.exists(w) ? mem[w] : (w[15:0] ^ 16'h5A3C);
  endfunction : arrayWord
  // Select decode of three pins
  assign sel = resetPowerdownN && ((!chipSelectTwo && !chipSelectOne &&
    !chipSelectZero) || (chipSelectTwo && !(chipSelectOne &&
    chipSelectZero)));
  always @(flashAddr[23:4] or sel) tSense = $realtime;
  always @(flashAddr[3:0]) tAddr = $realtime;
  always @(negedge outputEnableN) tOe = $realtime;
  always #1 tick = ~tick;
  // Output value, valid only after access times
  always @(tick) begin
    logic [15:0] w;
    logic        ok;
    w = statusMode ? ((busyCnt > 0) ? 16'h0000 : 16'h0080)
      : arrayWord(int'(flashAddr[23:1]));
    if (!wordWidthSel) w = {8'h00, flashAddr[0] ? w[15:8] : w[7:0]};
    ok = ($realtime >= tSense + flash_host_pkg::T_ACC_NS) &&
      ($realtime >= tAddr + flash_host_pkg::T_PAGE_NS) &&
      ($realtime >= tOe + flash_host_pkg::T_PAGE_NS);
    devOn = (sel && !outputEnableN) ? (wordWidthSel ? 16'hFFFF
      : 16'h00FF) : 16'h0000;
    devQ = ok ? w : ~lastQ;
  end
  // Undriven lanes flip every cycle
  assign dqIn = (dqOe & dqOut) | (~dqOe & devOn & devQ) |
    (~dqOe & ~devOn & ~lastQ);
  assign readyStatusPin = (busyCnt > 0) ? 1'b0 : 1'b1;
  always @(posedge mclk) begin
    lastQ <= dqIn;
    if (busyCnt > 0) busyCnt <= busyCnt - 1;
  end
  // Command capture at end of write cycle
  always @(posedge writeEnableN or negedge sel) begin
    if ((sel || !writeEnableN) && outputEnableN) begin
      if (armed) begin
        armed = 1'b0;
        statusMode = 1'b1;
        if (programEnableSupply) begin
          mem[int'(flashAddr[23:1])] = arrayWord(int'(flashAddr[23:1])) & dqIn;
          busyCnt = BUSY_CYC;
        end
      end else begin
        armed = (dqIn[7:0] == 8'h40);
        statusMode = (dqIn[7:0] == 8'h70) || (statusMode && dqIn[7:0] != 8'hFF);
      end
    end
  end
  // Reset/power-down returns to array reads
  always @(negedge resetPowerdownN) begin
    statusMode = 1'b0;
    armed = 1'b0;
    busyCnt = 0;
  end
endmodule : flash_device_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
  logic        byteMode = 1'b0, programEnable = 1'b0;
  logic [23:0] reqAddr = 24'h00_0000, flashAddr, a, base, pa;
  logic [15:0] reqData = 16'h0000, respData, dqOut, dqOe, dqIn;
  logic        reqReady, respValid, deviceBusy, chipSelectZero;
  logic        chipSelectOne, chipSelectTwo, outputEnableN, writeEnableN;
  logic        resetPowerdownN, wordWidthSel, programEnableSupply;
  logic        readyStatusPin;
  logic [16:0] notes [$];                  // Expected answers
  logic [16:0] note;
  logic [15:0] bmem [int];                 // Expected array words
  int          fails = 0, checked = 0, seed = 66254;
  always #(flash_host_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
  flash_host_ctrl #(.RESET_TO_OUTPUT_DELAY_NS(10)) DUT (.mclk, .rst,
    .reqValid, .reqWrite, .reqAddr, .reqData, .byteMode, .programEnable,
    .reqReady, .respValid, .respData, .deviceBusy, .flashAddr, .dqOut,
    .dqOe, .dqIn, .chipSelectZero, .chipSelectOne, .chipSelectTwo,
    .outputEnableN, .writeEnableN, .resetPowerdownN, .wordWidthSel,
    .programEnableSupply, .readyStatusPin);
  flash_device_model dev (.mclk, .flashAddr, .dqOut, .dqOe, .dqIn,
    .chipSelectZero, .chipSelectOne, .chipSelectTwo, .outputEnableN,
    .writeEnableN, .resetPowerdownN, .wordWidthSel, .programEnableSupply,
    .readyStatusPin);
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [15:0] expOf(input logic [23:0] x, input logic bm);
    logic [15:0] w;
    w = bmem.exists(int'(x[23:1])) ? bmem[int'(x[23:1])] : (x[16:1] ^ 16'h5A3C);
    return bm ? {8'h00, x[0] ? w[15:8] : w[7:0]} : w;
  endfunction : expOf
  // One request; valid stays up for back-to-back use
  task automatic doReq(input logic wr, input logic [23:0] x,
                       input logic [15:0] d, input logic bm,
                       input logic [15:0] e);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = x;
    reqData = d;
    byteMode = bm;
    @(negedge mclk);
    // A hang here is caught by the watchdog
    while (reqReady !== 1'b1) begin
      @(negedge mclk);
    end
    @(posedge mclk);
    notes.push_back({!wr, e});
    #1;
  endtask : doReq
  // Drop the request and let answers come back
  task automatic drain();
    reqValid = 1'b0;
    while (notes.size() != 0) begin
      @(posedge mclk);
    end
    @(posedge mclk);
    #1;
  endtask : drain
  task automatic waitBusy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (deviceBusy !== lvl && n < lim) begin
      @(negedge mclk);
      n++;
    end
    chk(16'(deviceBusy), 16'(lvl));
    @(posedge mclk);
    #1;
  endtask : waitBusy
  task automatic doReset();
    int n;
    n = 0;
    rst = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    while (reqReady !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk(16'(n >= 20 && n < 200), 16'h0001);
    chk(16'(deviceBusy), 16'h0000);
    @(posedge mclk);
    #1;
  endtask : doReset
  task automatic end_of_test();
    $display("TB: checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Answer watcher, oldest note first
  always @(negedge mclk) begin
    if (respValid === 1'b1 && notes.size() != 0) begin
      note = notes.pop_front();
      if (note[16]) chk(respData, note[15:0]);
    end
  end
  initial begin
    #200_000;
    fails++;
    end_of_test();
  end
  initial begin
    doReset();
    // Page reads, random tags, order and widths
    for (int p = 0; p < 6; p++) begin
      base = 24'($random(seed)) & 24'hFF_FFF0;
      for (int i = 0; i < 12; i++) begin
        a = base | (24'($random(seed)) & 24'h00_000F);
        doReq(1'b0, a, 16'h0000, p[0], expOf(a, p[0]));
      end
    end
    drain();
    $display("TB: page reads done");
    // Program, status, read-array, then lockout
    pa = 24'h01_2340;
    programEnable = 1'b1;
    doReq(1'b1, pa, 16'h0040, 1'b0, 16'h0000);
    doReq(1'b1, pa, 16'h0F0F, 1'b0, 16'h0000);
    bmem[int'(pa[23:1])] = expOf(pa, 1'b0) & 16'h0F0F;
    drain();
    waitBusy(1'b1, 40);
    waitBusy(1'b0, 100);
    doReq(1'b0, pa, 16'h0000, 1'b0, 16'h0080);
    doReq(1'b1, pa, 16'h00FF, 1'b0, 16'h0000);
    doReq(1'b0, pa, 16'h0000, 1'b0, expOf(pa, 1'b0));
    programEnable = 1'b0;
    doReq(1'b1, pa + 24'h00_0002, 16'h0040, 1'b0, 16'h0000);
    doReq(1'b1, pa + 24'h00_0002, 16'h0000, 1'b0, 16'h0000);
    doReq(1'b1, pa, 16'h00FF, 1'b1, 16'h0000);
    doReq(1'b0, pa + 24'h00_0002, 16'h0000, 1'b0, expOf(pa + 24'h00_0002, 1'b0));
    drain();
    chk(16'(deviceBusy), 16'h0000);
    $display("TB: program done");
    // Leave status mode by reset alone
    doReq(1'b1, pa, 16'h0070, 1'b0, 16'h0000);
    drain();
    doReset();
    doReq(1'b0, pa, 16'h0000, 1'b1, expOf(pa, 1'b1));
    doReq(1'b1, pa, 16'h0060, 1'b0, 16'h0000);
    doReq(1'b1, pa, 16'h0004, 1'b0, 16'h0000);
    a = pa | 24'h00_000B;
    doReq(1'b0, a, 16'h0000, 1'b1, expOf(a, 1'b1));
    doReq(1'b0, pa, 16'h0000, 1'b1, expOf(pa, 1'b1));
    drain();
    $display("TB: reset done");
    end_of_test();
  end
endmodule : tb_top
